// File: dlvi_cfg.svh
// Constants of the dual link video input: word layout and line timing
`ifndef DLVI_CFG_SVH
`define DLVI_CFG_SVH

// Each link word: four data pairs of seven bits, already deserialised
`define DLVI_LINK_W 28
`define DLVI_BLUE_LSB 0
`define DLVI_GREEN_LSB 8
`define DLVI_RED_LSB 16
`define DLVI_QUAL_BIT 24
`define DLVI_COMP_W 8

// Line and frame timing in link clock periods and lines
`define DLVI_ACTIVE_CLKS 960
`define DLVI_ACTIVE_LINES 1080
`define DLVI_HBLANK_MIN 74
`define DLVI_HBLANK_MAX 140
`define DLVI_LINE_PERIOD_MAX 1100

// Fifo depth in pixel pairs
`define DLVI_FIFO_DEPTH 8

`endif

// File: dlvi_pkg.sv
// Types shared by the dual link video input
`default_nettype none
package dlvi_pkg;
  // Framing state: between active lines or inside one
  typedef enum logic [0:0] {ST_GAP, ST_LINE} dlvi_state_t;
  typedef logic [23:0] dlvi_rgb_t;
  typedef logic [10:0] dlvi_pos_t;
endpackage : dlvi_pkg
`default_nettype wire

// File: dlvi_rx.sv
// Dual link video input: link sampling, framing, pixel pairing and fifo
//
// Operation
// - Lines and frames are framed only by the active video qualifier.
// - Pixels are placed left to right, top to bottom, as red, green, blue.
// - Each colour is eight bits with bit 7 the most significant.
// - Video comes on an odd and an even link, each with its own clock.
`timescale 1ns/1ps
`include "dlvi_cfg.svh"
`default_nettype none

module dlvi_fifo #(
  parameter int WIDTH = 71,
  parameter int DEPTH = `DLVI_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Pointer and count updates
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : dlvi_fifo

module dlvi_rx #(
  parameter int FIFO_DEPTH = `DLVI_FIFO_DEPTH
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic ODD_LINK_CLK_I,
  input wire logic [`DLVI_LINK_W-1:0] ODD_LINK_DATA_I,
  input wire logic EVEN_LINK_CLK_I,
  input wire logic [`DLVI_LINK_W-1:0] EVEN_LINK_DATA_I,
  input wire logic PIX_READY_I,
  output logic PIX_VALID_O,
  output logic [23:0] PIX_ODD_RGB_O,
  output logic [23:0] PIX_EVEN_RGB_O,
  output logic [10:0] PIX_COL_O,
  output logic [10:0] PIX_ROW_O,
  output logic PIX_SOF_O,
  output logic LINE_ERR_O,
  output logic OVERFLOW_O
);
  localparam int FW = 71;
  localparam int LW = `DLVI_LINK_W;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [2:0] odd_clk_s;
  logic [2:0] even_clk_s;
  logic [LW-1:0] odd_d0;
  logic [LW-1:0] odd_d1;
  logic [LW-1:0] even_d0;
  logic [LW-1:0] even_d1;
  logic odd_edge;
  logic even_edge;
  logic qual;

  dlvi_pkg::dlvi_state_t state;
  dlvi_pkg::dlvi_state_t next_state;
  logic [10:0] act_cnt;
  logic [10:0] next_act_cnt;
  logic [11:0] gap_cnt;
  logic [11:0] next_gap_cnt;
  dlvi_pkg::dlvi_pos_t row;
  dlvi_pkg::dlvi_pos_t next_row;
  logic top_pend;
  logic next_top_pend;
  dlvi_pkg::dlvi_rgb_t even_hold;
  dlvi_pkg::dlvi_rgb_t next_even_hold;
  logic push_valid;
  logic next_push_valid;
  logic [FW-1:0] push_data;
  logic [FW-1:0] next_push_data;
  logic line_err;
  logic next_line_err;
  logic overflow;
  logic next_overflow;
  logic fifo_ready;
  logic [FW-1:0] pop_data;

  // Pull one pixel out of a link word, colours as red, green, blue
  function automatic dlvi_pkg::dlvi_rgb_t link_rgb(
    input logic [LW-1:0] w
  );
    link_rgb = {w[`DLVI_RED_LSB +: `DLVI_COMP_W],
                w[`DLVI_GREEN_LSB +: `DLVI_COMP_W],
                w[`DLVI_BLUE_LSB +: `DLVI_COMP_W]};
  endfunction : link_rgb

  // Reset release through two flops
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Both link clocks and words cross through two flops; data delay matches
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      odd_clk_s <= 3'h0;
      even_clk_s <= 3'h0;
      odd_d0 <= '0;
      odd_d1 <= '0;
      even_d0 <= '0;
      even_d1 <= '0;
    end else begin
      odd_clk_s <= {odd_clk_s[1:0], ODD_LINK_CLK_I};
      even_clk_s <= {even_clk_s[1:0], EVEN_LINK_CLK_I};
      odd_d0 <= ODD_LINK_DATA_I;
      odd_d1 <= odd_d0;
      even_d0 <= EVEN_LINK_DATA_I;
      even_d1 <= even_d0;
    end
  end

  // Edges seen only from the second stage onward
  assign odd_edge = odd_clk_s[1] && !odd_clk_s[2];
  assign even_edge = even_clk_s[1] && !even_clk_s[2];
  assign qual = odd_d1[`DLVI_QUAL_BIT];

  // Framing from the qualifier alone; no sync inputs exist
  always_comb begin
    next_state = state;
    next_act_cnt = act_cnt;
    next_gap_cnt = gap_cnt;
    next_row = row;
    next_top_pend = top_pend;
    next_even_hold = even_hold;
    next_push_valid = 1'b0;
    next_push_data = push_data;
    next_line_err = 1'b0;
    next_overflow = overflow || (push_valid && !fifo_ready);
    if (even_edge) begin
      next_even_hold = link_rgb(even_d1);
    end
    if (odd_edge) begin
      unique case (state)
        dlvi_pkg::ST_LINE: begin
          if (qual) begin
            next_act_cnt = act_cnt + 11'h1;
            next_push_valid = 1'b1;
          end else begin
            next_state = dlvi_pkg::ST_GAP;
            next_gap_cnt = 12'h1;
            // A short or long line is flagged, not repaired
            next_line_err = (act_cnt != 11'(`DLVI_ACTIVE_CLKS));
          end
        end
        dlvi_pkg::ST_GAP: begin
          if (qual) begin
            next_state = dlvi_pkg::ST_LINE;
            next_act_cnt = 11'h1;
            next_push_valid = 1'b1;
            if (top_pend ||
                gap_cnt > 12'(`DLVI_LINE_PERIOD_MAX)) begin
              next_row = 11'h0;
              next_top_pend = 1'b0;
            end else begin
              next_row = (row == 11'h7ff) ? row : row + 11'h1;
              next_line_err = (gap_cnt < 12'(`DLVI_HBLANK_MIN)) ||
                              (gap_cnt > 12'(`DLVI_HBLANK_MAX));
            end
          end else if (gap_cnt != 12'hfff) begin
            next_gap_cnt = gap_cnt + 12'h1;
          end
        end
      endcase
      // Fresh even word wins over the held one when both edges coincide
      next_push_data = {link_rgb(odd_d1),
                        even_edge ? link_rgb(even_d1) : even_hold,
                        (state == dlvi_pkg::ST_GAP) ? 11'h0
                                                    : {act_cnt[9:0], 1'b0},
                        next_row,
                        (state == dlvi_pkg::ST_GAP) && (next_row == 11'h0)
                       };
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= dlvi_pkg::ST_GAP;
      act_cnt <= 11'h0;
      gap_cnt <= 12'h0;
      row <= 11'h0;
      top_pend <= 1'b1;
      even_hold <= 24'h0;
      push_valid <= 1'b0;
      push_data <= '0;
      line_err <= 1'b0;
      overflow <= 1'b0;
    end else begin
      state <= next_state;
      act_cnt <= next_act_cnt;
      gap_cnt <= next_gap_cnt;
      row <= next_row;
      top_pend <= next_top_pend;
      even_hold <= next_even_hold;
      push_valid <= next_push_valid;
      push_data <= next_push_data;
      line_err <= next_line_err;
      overflow <= next_overflow;
    end
  end

  // The link cannot be stalled, so a full fifo drops the pair and says so
  dlvi_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .in_valid_i(push_valid),
    .in_ready_o(fifo_ready),
    .in_data_i(push_data),
    .out_valid_o(PIX_VALID_O),
    .out_ready_i(PIX_READY_I),
    .out_data_o(pop_data)
  );

  assign PIX_ODD_RGB_O = pop_data[70:47];
  assign PIX_EVEN_RGB_O = pop_data[46:23];
  assign PIX_COL_O = pop_data[22:12];
  assign PIX_ROW_O = pop_data[11:1];
  assign PIX_SOF_O = pop_data[0];
  assign LINE_ERR_O = line_err;
  assign OVERFLOW_O = overflow;
endmodule : dlvi_rx
`default_nettype wire

// File: dlvi_rx_asserts.sv
// Port checks of the dual link video input
`timescale 1ns/1ps
`default_nettype none
module dlvi_rx_asserts #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic ODD_LINK_CLK_I,
  input wire logic [27:0] ODD_LINK_DATA_I,
  input wire logic EVEN_LINK_CLK_I,
  input wire logic [27:0] EVEN_LINK_DATA_I,
  input wire logic PIX_READY_I,
  input wire logic PIX_VALID_O,
  input wire logic [23:0] PIX_ODD_RGB_O,
  input wire logic [23:0] PIX_EVEN_RGB_O,
  input wire logic [10:0] PIX_COL_O,
  input wire logic [10:0] PIX_ROW_O,
  input wire logic PIX_SOF_O,
  input wire logic LINE_ERR_O,
  input wire logic OVERFLOW_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  // Consumer takes a pair, or leaves it waiting
  sequence s_pop;
    PIX_VALID_O && PIX_READY_I;
  endsequence
  sequence s_held;
    PIX_VALID_O && !PIX_READY_I;
  endsequence
  a_pair_held: assert property (s_held |=> PIX_VALID_O &&
    $stable(PIX_ODD_RGB_O) && $stable(PIX_EVEN_RGB_O) && $stable(PIX_COL_O))
    else $error("pair changed while stalled");
  a_col_even: assert property (PIX_VALID_O |->
    !PIX_COL_O[0] && PIX_COL_O <= 11'h77e) else $error("bad column");
  a_sof_origin: assert property (PIX_VALID_O |-> PIX_SOF_O ==
    (PIX_ROW_O == 11'h0 && PIX_COL_O == 11'h0)) else $error("bad start");
  // Back-to-back pops on one row step two pixels; drops excuse gaps
  a_col_step: assert property (s_pop ##1 PIX_VALID_O &&
    PIX_ROW_O == $past(PIX_ROW_O) && !OVERFLOW_O |->
    PIX_COL_O == $past(PIX_COL_O) + 11'h2) else $error("column skipped");
  a_valid_soon: assert property ($rose(ODD_LINK_CLK_I) &&
    ODD_LINK_DATA_I[24] |-> ##[1:6] PIX_VALID_O) else $error("pair lost");
  a_err_pulse: assert property (LINE_ERR_O |=> !LINE_ERR_O)
    else $error("error flag too long");
  a_ovf_sticky: assert property (OVERFLOW_O |=> OVERFLOW_O)
    else $error("overflow cleared");
  a_ovf_cause: assert property ($rose(OVERFLOW_O) |-> $past(PIX_VALID_O))
    else $error("overflow while not full");
endmodule : dlvi_rx_asserts
bind dlvi_rx dlvi_rx_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire

// File: dlvi_host.sv
// Host model: free running link clocks and video words
`timescale 1ns/1ps
`default_nettype none
module dlvi_host;
  logic run = 1'b0;
  logic odd_clk = 1'b0;
  logic even_clk = 1'b0;
  logic [27:0] odd_data = 28'h0;
  logic [27:0] even_data = 28'h0;
  int low_run = 0;
  // Clock held low until power is up and stopped low at its next half period when it drops;
  // the period is stretched so the system clock can oversample it
  always #100 odd_clk = run & ~odd_clk;
  // Idle words taken at the rising edge since the last active one
  always @(posedge odd_clk) low_run <= odd_data[24] ? 0 : low_run + 1;
  // Even link has its own clock, skewed from the odd one
  always @(odd_clk) even_clk <= #3 odd_clk;
  function automatic logic [23:0] px(input int k);
    return {k[7:0], ~k[7:0], 8'h3c ^ k[10:3]};
  endfunction : px
  // Blanking counts from the last active word, so a slow caller cannot
  // stretch it: the block sees exactly gap idle clocks, then the line
  task automatic line(input int gap, input int n);
    for (int w = 0; w < gap && low_run < gap - 1; w++) @(negedge odd_clk);
    for (int k = 0; k < n + 2; k++) begin
      @(negedge odd_clk);
      odd_data = {3'h0, k < n, px(k)};
      even_data = {4'h0, px(k) + 24'h1};
    end
  endtask : line
endmodule : dlvi_host
`default_nettype wire

// File: dlvi_rx_tb.sv
// Self-checking bench of the dual link video input
`timescale 1ns/1ps
`default_nettype none
module dlvi_rx_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ready = 1'b0;
  logic hold = 1'b0;
  logic mon = 1'b0;
  logic valid, sof, line_err, overflow;
  logic [23:0] odd_rgb, even_rgb;
  logic [10:0] col, row;
  logic [5:0] cyc = 6'h0;
  int failures = 0;
  int checks = 0;
  int idx = 0;
  int exp_row = 0;
  int errs = 0;
  int e0;
  // Rows: idle clocks before the line, active count, error count, row
  int r_gap[7] = '{80, 74, 140, 73, 141, 80, 1101};
  int r_n[7] = '{960, 960, 960, 960, 960, 959, 960};
  int r_err[7] = '{0, 0, 0, 1, 1, 1, 0};
  int r_row[7] = '{0, 1, 2, 3, 4, 5, 0};
  dlvi_host host();
  dlvi_rx #(.FIFO_DEPTH(8)) dut (.CLK_SYS_I(clk), .RSTN_I(rst_n),
    .ODD_LINK_CLK_I(host.odd_clk), .ODD_LINK_DATA_I(host.odd_data),
    .EVEN_LINK_CLK_I(host.even_clk), .EVEN_LINK_DATA_I(host.even_data),
    .PIX_READY_I(ready), .PIX_VALID_O(valid), .PIX_ODD_RGB_O(odd_rgb),
    .PIX_EVEN_RGB_O(even_rgb), .PIX_COL_O(col), .PIX_ROW_O(row),
    .PIX_SOF_O(sof), .LINE_ERR_O(line_err), .OVERFLOW_O(overflow));
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Bounded wait for the stream to run dry
  task automatic drain();
    int n;
    for (n = 0; n < 200 && valid !== 1'b0; n++) @(negedge clk);
    if (n == 200) begin
      failures++;
      report_and_stop();
    end
  endtask : drain
  // Consumer stalls a quarter of the time so pairs pile up
  always @(negedge clk) begin
    cyc <= cyc + 6'h1;
    ready <= !hold && cyc[5:4] != 2'h0;
  end
  // Watchdog in case the link stops and a wait never returns
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  // Every pair taken while mon is set is compared with the pixel the host sent
  always @(posedge clk) begin
    if (line_err === 1'b1) errs++;
    if (mon && valid === 1'b1 && ready === 1'b1) begin
      chk(odd_rgb, host.px(idx) ^ 24'h0);
      chk(even_rgb, {idx[7:0], ~idx[7:0], 8'h3c ^ idx[10:3]} + 24'h1);
      chk(col, 2 * idx);
      chk(row, exp_row);
      chk(sof, exp_row == 0 && idx == 0);
      idx++;
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    #1003 host.run = 1'b1;
    mon = 1'b1;
    for (int i = 0; i < 7; i++) begin
      idx = 0;
      exp_row = r_row[i];
      e0 = errs;
      host.line(r_gap[i], r_n[i]);
      drain();
      chk(idx, r_n[i]);
      chk(errs - e0, r_err[i]);
    end
    // Consumer stops: fifo fills, later pairs are dropped
    mon = 1'b0;
    hold = 1'b1;
    host.line(80, 20);
    chk({valid, overflow}, 2'h3);
    hold = 1'b0;
    drain();
    chk(overflow, 1'b1);
    // Reset in mid-run clears all but the fifo storage and top_pend, which it sets; the sticky flag clears too
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk({valid, overflow, line_err, sof}, 4'h0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(overflow, 1'b0);
    // First line after a reset is a frame top even after a short gap
    mon = 1'b1;
    idx = 0;
    exp_row = 0;
    e0 = errs;
    host.line(80, 20);
    drain();
    chk(idx, 20);
    chk(errs - e0, 1);
    report_and_stop();
  end
endmodule : dlvi_rx_tb
`default_nettype wire
